// >>> design/css_match_unit.sv
// Per-channel match hardware: pin transition and request on match
`timescale 1ns/100ps
`include "css_consts.svh"

module css_match_unit #(
  parameter int TIME_W = `CSS_TIME_W
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [TIME_W-1:0] time_base,
  input  wire logic              arm,
  input  wire logic [TIME_W-1:0] arm_time,
  input  wire logic              arm_level,
  output logic                   pin,
  output logic                   match
);
  import css_pkg::*;

  logic              armed_q, armed_d;   // Transition pending
  logic [TIME_W-1:0] mtime_q, mtime_d;   // Programmed match time
  logic              mlvl_q,  mlvl_d;    // Level to drive at match
  logic              pin_q,   pin_d;     // Channel pin level
  logic              hit_q,   hit_d;     // One-cycle match pulse

  // Arm, compare and drive the pin independently of the execution unit
  always_comb begin
    armed_d = armed_q;
    mtime_d = mtime_q;
    mlvl_d  = mlvl_q;
    pin_d   = pin_q;
    hit_d   = 1'b0;
    if (armed_q && (time_base == mtime_q)) begin
      pin_d   = mlvl_q;
      hit_d   = 1'b1;
      armed_d = 1'b0;
    end
    if (arm) begin
      // New setup replaces any pending one
      armed_d = 1'b1;
      mtime_d = arm_time;
      mlvl_d  = arm_level;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
      mtime_q <= '0;
      mlvl_q  <= 1'b0;
      pin_q   <= 1'b0;
      hit_q   <= 1'b0;
    end else begin
      armed_q <= armed_d;
      mtime_q <= mtime_d;
      mlvl_q  <= mlvl_d;
      pin_q   <= pin_d;
      hit_q   <= hit_d;
    end
  end

  assign pin   = pin_q;
  assign match = hit_q;

endmodule

// >>> design/css_scheduler.sv
// Channel service scheduler: slot sequence, passing and latches
`timescale 1ns/100ps
`include "css_consts.svh"

module css_scheduler #(
  parameter int NUM_CH = `CSS_NUM_CH,
  parameter int TIME_W = `CSS_TIME_W
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [NUM_CH-1:0][1:0] chan_prio,
  input  wire logic [NUM_CH-1:0]      host_req,
  input  wire logic [TIME_W-1:0]      time_base,
  input  wire css_pkg::css_setup_s    setup,
  input  wire logic                   eu_done,
  output css_pkg::css_grant_s         grant,
  output logic [2:0]                  slot_pos,
  output logic                        busy,
  output logic [NUM_CH-1:0]           chan_pin,
  output logic [NUM_CH-1:0]           req_latch,
  output logic [NUM_CH-1:0]           grant_latch
);
  import css_pkg::*;

  // Refuse sizes the 4-bit channel number cannot serve
  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
    $error("NUM_CH must be 1 to 16");
  end
  if (TIME_W != 16) begin : g_bad_tw
    $error("TIME_W must match the 16-bit setup time");
  end

  localparam logic [3:0] XFER_LAST = 4'(`CSS_XFER_CLK - 1);
  localparam logic [3:0] NOP_LAST  = 4'(`CSS_NOP_CLK - 1);

  // Level of each position in the seven-slot sequence
  function automatic css_level_e slot_level(input logic [2:0] pos);
    case (pos)
      3'h0, 3'h2, 3'h4, 3'h6: slot_level = CSS_HIGH;
      3'h1, 3'h5:             slot_level = CSS_MID;
      3'h3:                   slot_level = CSS_LOW;
      default:                slot_level = CSS_HIGH;
    endcase
  endfunction

  // k-th level tried in a slot of level cur (k = 0 is the owner)
  function automatic css_level_e pass_level(input css_level_e cur,
                                            input logic [1:0] k);
    pass_level = cur;
    case (cur)
      CSS_HIGH: begin
        if (k == 2'h1) pass_level = CSS_MID;
        if (k == 2'h2) pass_level = CSS_LOW;
      end
      CSS_MID: begin
        if (k == 2'h1) pass_level = CSS_HIGH;
        if (k == 2'h2) pass_level = CSS_LOW;
      end
      CSS_LOW: begin
        if (k == 2'h1) pass_level = CSS_HIGH;
        if (k == 2'h2) pass_level = CSS_MID;
      end
      default: pass_level = cur;
    endcase
  endfunction

  // Channels whose priority field selects level lv
  function automatic logic [NUM_CH-1:0] level_mask(
      input logic [NUM_CH-1:0][1:0] prio, input css_level_e lv);
    level_mask = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      // Field 00 never equals a live level
      level_mask[i] = (prio[i] == lv) && (lv != CSS_OFF);
    end
  endfunction

  // Index of the lowest set bit
  function automatic logic [3:0] lowest(input logic [NUM_CH-1:0] v);
    lowest = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) lowest = 4'(i);
    end
  endfunction

  css_state_e         state_q, state_d;  // Scheduler state
  logic [2:0]         slot_q,  slot_d;   // Sequence position
  logic [3:0]         cnt_q,   cnt_d;    // Nop/transition counter
  logic [NUM_CH-1:0]  srl_q,   srl_d;    // service_request_latch
  logic [NUM_CH-1:0]  sgl_q,   sgl_d;    // service_grant_latch
  logic               gval_q,  gval_d;   // Grant pulse
  logic [3:0]         gch_q,   gch_d;    // Granted channel
  css_level_e         glv_q,   glv_d;    // Level of the granted channel
  logic               clr_q,   clr_d;    // Group clear pending

  logic [NUM_CH-1:0]  match_evt;         // Match pulses per channel
  logic [NUM_CH-1:0]  elig [3];          // Eligible sets per pass step
  logic [NUM_CH-1:0]  pend;              // Served level still pending
  css_level_e         try_lv [3];        // Levels in passing order

  // Per-channel match hardware, each free-running
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    css_match_unit #(
      .TIME_W    (TIME_W)
    ) u_match (
      .clk       (clk),
      .arst_n    (arst_n),
      .time_base (time_base),
      .arm       (setup.valid && (setup.chan == 4'(c))),
      .arm_time  (setup.time_val),
      .arm_level (setup.level),
      .pin       (chan_pin[c]),
      .match     (match_evt[c])
    );
  end

  // Eligible requesters for each level in passing order
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      try_lv[k] = pass_level(slot_level(slot_q), 2'(k));
      // Request set, grant clear, channel enabled
      elig[k] = srl_q & ~sgl_q & level_mask(chan_prio, try_lv[k]);
    end
    pend = srl_q & ~sgl_q & level_mask(chan_prio, glv_q);
  end

  // Next-state logic of the scheduler
  always_comb begin
    state_d = state_q;
    slot_d  = slot_q;
    cnt_d   = cnt_q;
    gval_d  = 1'b0;
    gch_d   = gch_q;
    glv_d   = glv_q;
    clr_d   = clr_q;
    sgl_d   = sgl_q;
    srl_d   = srl_q;
    case (state_q)
      CSS_ARB: begin
        // Owner level first, then passed levels, same cycle
        if (elig[0] != '0 || elig[1] != '0 || elig[2] != '0) begin
          if (elig[0] != '0) begin
            gch_d = lowest(elig[0]);
            glv_d = try_lv[0];
          end else if (elig[1] != '0) begin
            gch_d = lowest(elig[1]);
            glv_d = try_lv[1];
          end else begin
            gch_d = lowest(elig[2]);
            glv_d = try_lv[2];
          end
          gval_d        = 1'b1;
          sgl_d[gch_d]  = 1'b1;
          srl_d[gch_d]  = 1'b0;
          slot_d  = (slot_q == `CSS_SLOT_LAST) ? 3'h0 : 3'(slot_q + 3'h1);
          state_d = CSS_SERV;
        end
        // No requester: slot position held
      end
      CSS_SERV: begin
        // One function state per slot, any length
        if (eu_done) begin
          if (pend == '0) begin
            state_d = CSS_NOP;
            cnt_d   = NOP_LAST;
          end else begin
            state_d = CSS_XFER;
            cnt_d   = XFER_LAST;
          end
        end
      end
      CSS_NOP: begin
        // Four-clock idle that clears the served level's grants
        if (cnt_q == 4'h0) begin
          sgl_d   = sgl_q & ~level_mask(chan_prio, glv_q);
          state_d = CSS_XFER;
          cnt_d   = XFER_LAST;
        end else begin
          cnt_d = 4'(cnt_q - 4'h1);
        end
      end
      CSS_XFER: begin
        // Ten-clock preparation before the next slot
        if (cnt_q == 4'h0) begin
          state_d = CSS_ARB;
        end else begin
          cnt_d = 4'(cnt_q - 4'h1);
        end
      end
      default: state_d = CSS_ARB;
    endcase
    clr_d = (state_d == CSS_NOP);
    // New requests win over a grant in the same cycle
    srl_d = srl_d | match_evt | host_req;
  end

  // Scheduler registers; reset starts at slot zero, latches clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CSS_ARB;
      slot_q  <= 3'h0;
      cnt_q   <= 4'h0;
      srl_q   <= '0;
      sgl_q   <= '0;
      gval_q  <= 1'b0;
      gch_q   <= 4'h0;
      glv_q   <= CSS_OFF;
      clr_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q  <= slot_d;
      cnt_q   <= cnt_d;
      srl_q   <= srl_d;
      sgl_q   <= sgl_d;
      gval_q  <= gval_d;
      gch_q   <= gch_d;
      glv_q   <= glv_d;
      clr_q   <= clr_d;
    end
  end

  // Outputs
  assign grant.valid = gval_q;
  assign grant.chan  = gch_q;
  assign grant.level = glv_q;
  assign slot_pos    = slot_q;
  assign busy        = (state_q != CSS_ARB) || clr_q;
  assign req_latch   = srl_q;
  assign grant_latch = sgl_q;

endmodule

// >>> include/css_consts.svh
// Constants for the channel service scheduler
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_NUM_CH      16
`define CSS_SLOTS       7
`define CSS_SLOT_LAST   3'h6
`define CSS_XFER_CLK    10
`define CSS_NOP_CLK     4
`define CSS_TIME_W      16
`define CSS_PRIO_OFF    2'h0
`define CSS_PRIO_LOW    2'h1
`define CSS_PRIO_MID    2'h2
`define CSS_PRIO_HIGH   2'h3

`endif

// >>> include/css_pkg.sv
// Types shared by the channel service scheduler files
package css_pkg;

  // Priority level, same coding as the channel priority field
  typedef enum logic [1:0] {
    CSS_OFF  = 2'h0,
    CSS_LOW  = 2'h1,
    CSS_MID  = 2'h2,
    CSS_HIGH = 2'h3
  } css_level_e;

  // Scheduler states, Gray along arbitrate-serve-nop-transition
  typedef enum logic [1:0] {
    CSS_ARB  = 2'h0,
    CSS_SERV = 2'h1,
    CSS_NOP  = 2'h3,
    CSS_XFER = 2'h2
  } css_state_e;

  // Pin transition set up in advance by the execution unit
  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [15:0] time_val;
    logic        level;
  } css_setup_s;

  // Grant handed to the execution unit
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    css_level_e level;
  } css_grant_s;

endpackage

// >>> verification/css_eu_model.sv
// Behavioural execution unit answering each grant after a set delay
`timescale 1ns/100ps
module css_eu_model (
  input  logic                clk,
  input  logic                arst_n,
  input  css_pkg::css_grant_s grant,   // Grant from the scheduler
  input  logic [7:0]          svc_len, // Cycles per state, at least 1
  output logic                eu_done  // One-cycle end-of-state pulse
);
  logic [7:0] cnt_q; // Cycles left in the running state
  // One function state per grant, finish pulsed once
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= 8'h00;
      eu_done <= 1'b0;
    end else if (grant.valid === 1'b1) begin
      cnt_q   <= svc_len;
      eu_done <= #1 1'b0;
    end else begin
      eu_done <= #1 (cnt_q == 8'h01);
      if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// >>> verification/css_sched_monitor.sv
// Checker for the channel service scheduler, bound to its ports
`timescale 1ns/100ps
module css_sched_monitor #(
  parameter int NUM_CH = 16
) (
  input logic                   clk,
  input logic                   arst_n,
  input logic [NUM_CH-1:0][1:0] chan_prio,
  input logic                   eu_done,
  input css_pkg::css_grant_s    grant,
  input logic [2:0]             slot_pos,
  input logic                   busy,
  input logic [NUM_CH-1:0]      req_latch,
  input logic [NUM_CH-1:0]      grant_latch
);
  import css_pkg::*;
  logic [NUM_CH-1:0] en;         // Channels with a priority set
  logic              elig;       // Some enabled channel awaits service
  logic [NUM_CH-1:0] req_prev_q; // Request latches one cycle back
  logic              pend_lv;    // Served level still has a waiting channel
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Enabled mask from the priority fields
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) en[i] = |chan_prio[i];
  end
  assign elig = |(req_latch & ~grant_latch & en);
  // Waiting channel of the level last granted, request set, grant clear
  always_comb begin
    pend_lv = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (req_latch[i] && !grant_latch[i] && chan_prio[i] == grant.level)
        pend_lv = 1'b1;
    end
  end
  // Delayed copy of the request latches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) req_prev_q <= '0;
    else req_prev_q <= req_latch;
  end
  // Ten busy cycles of transition, four of group clearing
  sequence s_xfer; busy [*8] ##1 busy [*2]; endsequence
  sequence s_nop; busy [*4]; endsequence
  chk_arb_grant: assert property (!busy && elig |=> grant.valid)
    else $error("waiting request not granted next cycle");
  chk_idle_hold: assert property (
    !busy && !elig |=> $stable(slot_pos) && !grant.valid)
    else $error("slot moved with nothing to serve");
  chk_grant_once: assert property (grant.valid |=> !grant.valid)
    else $error("grant pulse longer than one cycle");
  chk_grant_cause: assert property (
    grant.valid |-> $past(!busy) && busy)
    else $error("grant while execution unit in use");
  chk_slot_step: assert property (grant.valid |-> slot_pos ==
    ($past(slot_pos) == 3'h6 ? 3'h0 : $past(slot_pos) + 3'h1))
    else $error("slot position did not step");
  chk_latch_upd: assert property (grant.valid |->
    grant_latch[grant.chan] && req_prev_q[grant.chan])
    else $error("granted channel latches wrong");
  chk_prio_on: assert property (grant.valid |->
    chan_prio[grant.chan] != 2'h0 && grant.level == chan_prio[grant.chan])
    else $error("grant level or enable wrong");
  chk_slot_gap: assert property (
    eu_done && busy && pend_lv |=> s_xfer ##1 !busy)
    else $error("gap after slot not 10 cycles");
  chk_nop_gap: assert property (
    eu_done && busy && !pend_lv |=> s_nop ##1 s_xfer ##1 !busy)
    else $error("gap after group clear not 14 cycles");
endmodule

bind css_scheduler css_sched_monitor #(.NUM_CH(NUM_CH)) mon_u (
  .clk(clk), .arst_n(arst_n), .chan_prio(chan_prio), .eu_done(eu_done),
  .grant(grant), .slot_pos(slot_pos), .busy(busy),
  .req_latch(req_latch), .grant_latch(grant_latch));

// >>> verification/testbench.sv
// Self-checking bench for the channel service scheduler
`timescale 1ns/100ps
module testbench;
  import css_pkg::*;
  typedef struct {logic [15:0] req; logic [3:0] ch; css_level_e lv;} css_row_s;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [15:0][1:0] chan_prio = 32'h000005AF; // 0,1 high 2,3 mid 4,5 low
  logic [15:0]      host_req = 16'h0000;
  logic [15:0]      time_base = 16'h0000;
  css_setup_s       setup = '0;
  logic             eu_done;
  logic [7:0]       svc_len = 8'h01;
  css_grant_s       grant;
  logic [2:0]       slot_pos;
  logic [2:0]       exp_slot = 3'h0;
  logic             busy;
  logic [15:0]      chan_pin, req_latch, grant_latch;
  int               err_total = 0;
  int               checks = 0;
  // Request mask, first expected grant; slot known from grant count
  css_row_s rows [8] = '{'{16'h0010, 4'h4, CSS_LOW}, '{16'h0001, 4'h0,
    CSS_HIGH}, '{16'h0005, 4'h0, CSS_HIGH}, '{16'h0004, 4'h2, CSS_MID},
    '{16'h0010, 4'h4, CSS_LOW}, '{16'h0003, 4'h0, CSS_HIGH},
    '{16'h0058, 4'h3, CSS_MID}, '{16'h0001, 4'h0, CSS_HIGH}};
  css_scheduler dut_u (.clk(clk), .arst_n(arst_n), .chan_prio(chan_prio),
    .host_req(host_req), .time_base(time_base), .setup(setup),
    .eu_done(eu_done), .grant(grant), .slot_pos(slot_pos), .busy(busy),
    .chan_pin(chan_pin), .req_latch(req_latch), .grant_latch(grant_latch));
  css_eu_model eu_u (.clk(clk), .arst_n(arst_n), .grant(grant),
    .svc_len(svc_len), .eu_done(eu_done));
  // Clock and free-running time base
  always #50 clk = ~clk;
  always @(posedge clk) time_base <= #1 time_base + 16'h0001;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse_req(input logic [15:0] m);
    @(posedge clk) #1 host_req = m;
    @(posedge clk) #1 host_req = 16'h0000;
  endtask
  // Waits for a grant under a bound and compares it
  task automatic wait_grant(input logic [3:0] ch, input css_level_e lv);
    int n;
    n = 0;
    while (grant.valid !== 1'b1 && n < 300) begin
      @(posedge clk) #1 n++;
    end
    // A grant that never came counts as a mismatch
    if (grant.valid !== 1'b1) err_total++;
    check(grant.chan, ch);
    check(grant.level, lv);
    @(posedge clk) #1;
  endtask
  // Waits until nothing enabled is pending and the unit is free
  task automatic wait_idle;
    int n;
    n = 0;
    while ((busy !== 1'b0 || (req_latch & 16'h003F) != 0) && n < 500) begin
      @(posedge clk) #1 n++;
    end
    // Still busy at the limit counts as a mismatch
    if (busy !== 1'b0 || (req_latch & 16'h003F) != 0) err_total++;
  endtask
  // Slot position follows every grant
  always @(posedge clk) begin
    #2;
    if (grant.valid === 1'b1) begin
      exp_slot = (exp_slot == 3'h6) ? 3'h0 : exp_slot + 3'h1;
      check(slot_pos, exp_slot);
    end
  end
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    check({grant, slot_pos, busy}, '0);
    check(req_latch | grant_latch | chan_pin, '0);
    $display("reset test done");
    foreach (rows[i]) begin
      pulse_req(rows[i].req);
      wait_grant(rows[i].ch, rows[i].lv);
      wait_idle();
    end
    $display("passing table done");
    svc_len = 8'h1E;
    pulse_req(16'h0003);
    wait_grant(4'h0, CSS_HIGH);
    pulse_req(16'h0001);
    wait_grant(4'h1, CSS_HIGH);
    wait_grant(4'h0, CSS_HIGH);
    wait_idle();
    check(grant_latch & 16'h003F, 16'h0000);
    $display("rotation test done");
    @(posedge clk) #1 setup = {1'b1, 4'h8, time_base + 16'h0040, 1'b1};
    @(posedge clk) #1 setup = {1'b1, 4'h9, time_base + 16'h003F, 1'b1};
    @(posedge clk) #1 setup = '0;
    repeat (80) if (chan_pin[8] !== 1'b1) @(posedge clk) #1;
    check(chan_pin[9:8], 2'h3);
    @(posedge clk) #1 check(req_latch[9:8], 2'h3);
    // Falling transition on one pin leaves the other alone
    @(posedge clk) #1 setup = {1'b1, 4'h9, time_base + 16'h0008, 1'b0};
    @(posedge clk) #1 setup = '0;
    repeat (20) @(posedge clk);
    #1 check(chan_pin[9:8], 2'h1);
    $display("pin test done");
    repeat (30) @(posedge clk);
    #1 check({busy, slot_pos}, {1'b0, exp_slot});
    $display("idle test done");
    // Reset in mid-run: latched requests and raised pins must clear
    @(posedge clk) #1 arst_n = 1'b0;
    #10 check(req_latch | grant_latch | chan_pin, '0);
    check({grant, slot_pos, busy}, '0);
    exp_slot = 3'h0;
    @(posedge clk) #1 arst_n = 1'b1;
    pulse_req(16'h0010);
    wait_grant(4'h4, CSS_LOW);
    wait_idle();
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
